// [hw/pcra_top.sv]
// Chosen here: register access over APB.
`timescale 1ns/1ps
module pcra_top (
    // clock and reset
    input  wire logic                       clock_i,
    input  wire logic                       rst_i,
    // apb slave
    input  wire logic                       psel_i,
    input  wire logic                       penable_i,
    input  wire logic                       pwrite_i,
    input  wire logic [pcra_pkg::ADDR_W-1:0] paddr_i,
    input  wire logic [31:0]                pwdata_i,
    output logic      [31:0]                prdata_o,
    output logic                            pready_o,
    output logic                            pslverr_o,
    // message handling configuration
    output logic                            as_mode_en_o,
    output logic                            ptp_mode_en_o,
    output logic                            detect_eth_o,
    output logic                            detect_ipv4_o,
    output logic                            detect_ipv6_o,
    output logic                            peer_to_peer_transparent_o,
    output logic                            master_sel_o,
    output logic                            one_step_o,
    // running clock
    output logic      [15:0]                rtc_sec_o,
    output logic      [29:0]                rtc_ns_o,
    output logic                            temp_adjusting_o
);
    import pcra_pkg::*;

    typedef struct packed {
        logic [15:0]       sec_low;
        logic              rate_direction_sel;
        logic              temp_adj;
        logic [RATE_HI_W-1:0] rate_hi;
        logic [15:0]       rate_lo;
        logic [15:0]       dur_hi;
        logic [15:0]       dur_lo;
        logic [7:0]        cfg;
        logic              cont_adj;
        logic              clk_en;
        logic [31:0]       dur_cnt;
        logic [15:0]       rtc_sec;
        logic [29:0]       rtc_ns;
        logic [RATE_W-1:0] rtc_frac;
        logic [31:0]       prdata;
        logic              pready;
        logic              pslverr;
    } pcra_st_t;

    pcra_st_t          st;
    pcra_st_t          next_st;
    logic              tick;
    logic              access;
    logic              addr_ok;
    logic              wr;
    logic              adj_act;
    logic [RATE_W-1:0] fractional_rate_value;
    logic [30:0]       frac_sum;
    logic [30:0]       ns_sum;
    logic [15:0]       rd_word;

    function automatic logic reg_hit(input logic [ADDR_W-1:0] a, input logic [15:0] idx);
        reg_hit = (a == {idx[13:0], 2'b00});
    endfunction

    pcra_tick u_tick (
        .clock_i (clock_i),
        .rst_i   (rst_i),
        .tick_o  (tick)
    );

    assign access  = psel_i && penable_i;
    assign addr_ok = reg_hit(paddr_i, IDX_CLK_CTRL) || reg_hit(paddr_i, IDX_SEC_LOW)
                  || reg_hit(paddr_i, IDX_RATE_HIGH) || reg_hit(paddr_i, IDX_RATE_LOW)
                  || reg_hit(paddr_i, IDX_DUR_HIGH) || reg_hit(paddr_i, IDX_DUR_LOW)
                  || reg_hit(paddr_i, IDX_MSG_CFG1);
    // write lands at the edge where the master sees pready
    assign wr      = access && st.pready && pwrite_i && !st.pslverr;
    assign fractional_rate_value = {st.rate_hi, st.rate_lo};
    // temporary mode counts only while ticks remain
    assign adj_act = st.cont_adj || (st.temp_adj && st.dur_cnt != 32'h0000_0000);

    always_comb begin
        rd_word = WORD_RESET;
        if (reg_hit(paddr_i, IDX_CLK_CTRL)) begin
            // strobes self-clear, so they read zero
            rd_word = {13'h0000, st.cont_adj, st.clk_en, 1'b0};
        end else if (reg_hit(paddr_i, IDX_SEC_LOW)) begin
            rd_word = st.sec_low;
        end else if (reg_hit(paddr_i, IDX_RATE_HIGH)) begin
            rd_word = {st.rate_direction_sel, st.temp_adj, st.rate_hi};
        end else if (reg_hit(paddr_i, IDX_RATE_LOW)) begin
            rd_word = st.rate_lo;
        end else if (reg_hit(paddr_i, IDX_DUR_HIGH)) begin
            rd_word = st.dur_hi;
        end else if (reg_hit(paddr_i, IDX_DUR_LOW)) begin
            rd_word = st.dur_lo;
        end else if (reg_hit(paddr_i, IDX_MSG_CFG1)) begin
            rd_word = {8'h00, st.cfg};
        end
    end

    always_comb begin
        next_st         = st;
        next_st.pready  = 1'b0;
        next_st.pslverr = 1'b0;
        frac_sum        = {1'b0, st.rtc_frac};
        ns_sum          = {1'b0, st.rtc_ns};

        // one wait state: answer in the second access cycle
        if (access && !st.pready) begin
            next_st.pready  = 1'b1;
            next_st.pslverr = !addr_ok;
            next_st.prdata  = (addr_ok && !pwrite_i) ? {16'h0000, rd_word} : 32'h0000_0000;
        end

        // temporary adjustment ran out of ticks
        if (st.temp_adj && st.dur_cnt == 32'h0000_0000) begin
            next_st.temp_adj = 1'b0;
        end

        if (tick && st.clk_en) begin
            if (adj_act) begin
                if (st.rate_direction_sel) begin
                    frac_sum = {1'b0, st.rtc_frac} + {1'b0, fractional_rate_value};
                end else begin
                    frac_sum = {1'b0, st.rtc_frac} - {1'b0, fractional_rate_value};
                end
            end
            // carry bumps a nanosecond up; borrow takes one off the tick's step
            if (frac_sum[30] && st.rate_direction_sel) begin
                ns_sum = {1'b0, st.rtc_ns} + 31'(TICK_NS) + 31'h0000_0001;
            end else if (frac_sum[30]) begin
                ns_sum = {1'b0, st.rtc_ns} + 31'(TICK_NS) - 31'h0000_0001;
            end else begin
                ns_sum = {1'b0, st.rtc_ns} + 31'(TICK_NS);
            end
            next_st.rtc_frac = frac_sum[29:0];
            if (ns_sum >= 31'(NS_PER_SEC)) begin
                next_st.rtc_ns  = 30'(ns_sum - 31'(NS_PER_SEC));
                next_st.rtc_sec = st.rtc_sec + 16'h0001;
            end else begin
                next_st.rtc_ns = ns_sum[29:0];
            end
            if (st.temp_adj && st.dur_cnt != 32'h0000_0000) begin
                next_st.dur_cnt = st.dur_cnt - 32'h0000_0001;
            end
        end

        // software after hardware, so a same-cycle write wins
        if (wr) begin
            if (reg_hit(paddr_i, IDX_CLK_CTRL)) begin
                next_st.clk_en   = pwdata_i[CTRL_EN_BIT];
                next_st.cont_adj = pwdata_i[CTRL_CONT_BIT];
                if (pwdata_i[CTRL_READ_BIT]) begin
                    next_st.sec_low = st.rtc_sec;
                end
                if (pwdata_i[CTRL_RESET_BIT]) begin
                    next_st.rtc_sec  = 16'h0000;
                    next_st.rtc_ns   = 30'h0000_0000;
                    next_st.rtc_frac = 30'h0000_0000;
                end else if (pwdata_i[CTRL_LOAD_BIT]) begin
                    next_st.rtc_sec = st.sec_low;
                end
            end
            if (reg_hit(paddr_i, IDX_SEC_LOW)) begin
                next_st.sec_low = pwdata_i[15:0];
            end
            if (reg_hit(paddr_i, IDX_RATE_HIGH)) begin
                next_st.rate_direction_sel = pwdata_i[RATE_DIR_BIT];
                next_st.rate_hi            = pwdata_i[RATE_HI_W-1:0];
                next_st.temp_adj           = pwdata_i[TEMP_ADJ_BIT];
                if (pwdata_i[TEMP_ADJ_BIT] && !st.temp_adj) begin
                    next_st.dur_cnt = {st.dur_hi, st.dur_lo};
                end
            end
            if (reg_hit(paddr_i, IDX_RATE_LOW)) begin
                next_st.rate_lo = pwdata_i[15:0];
            end
            if (reg_hit(paddr_i, IDX_DUR_HIGH)) begin
                next_st.dur_hi = pwdata_i[15:0];
            end
            if (reg_hit(paddr_i, IDX_DUR_LOW)) begin
                next_st.dur_lo = pwdata_i[15:0];
            end
            if (reg_hit(paddr_i, IDX_MSG_CFG1)) begin
                next_st.cfg = pwdata_i[7:0];
            end
        end
    end

    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            st     <= '0;
            st.cfg <= MSG_CFG1_RESET;
        end else begin
            st <= next_st;
        end
    end

    assign prdata_o                   = st.prdata;
    assign pready_o                   = st.pready;
    assign pslverr_o                  = st.pslverr;
    assign as_mode_en_o               = st.cfg[CFG_AS_BIT];
    assign ptp_mode_en_o              = st.cfg[CFG_PTP_BIT];
    assign detect_eth_o               = st.cfg[CFG_ETH_BIT];
    assign detect_ipv4_o              = st.cfg[CFG_IPV4_BIT];
    assign detect_ipv6_o              = st.cfg[CFG_IPV6_BIT];
    assign peer_to_peer_transparent_o = st.cfg[CFG_P2P_BIT];
    assign master_sel_o               = st.cfg[CFG_MST_BIT];
    assign one_step_o                 = st.cfg[CFG_ONE_BIT];
    assign rtc_sec_o                  = st.rtc_sec;
    assign rtc_ns_o                   = st.rtc_ns;
    assign temp_adjusting_o           = st.temp_adj;

    // checks
    logic              wr_ctrl;
    logic              wr_rate_hi;
    logic              wr_cfg;
    logic [RATE_W-1:0] exp_add;
    logic [RATE_W-1:0] exp_sub;
    assign wr_ctrl    = wr && reg_hit(paddr_i, IDX_CLK_CTRL);
    assign wr_rate_hi = wr && reg_hit(paddr_i, IDX_RATE_HIGH);
    assign wr_cfg     = wr && reg_hit(paddr_i, IDX_MSG_CFG1);
    assign exp_add    = st.rtc_frac + fractional_rate_value;
    assign exp_sub    = st.rtc_frac - fractional_rate_value;

    default clocking cb @(posedge clock_i); endclocking
    default disable iff (rst_i);

    sequence s_access_start;
        psel_i && penable_i && !pready_o;
    endsequence

    sequence s_adj_tick;
        tick && st.clk_en && adj_act && !wr_ctrl;
    endsequence

    AST_APB_ONE_WAIT: assert property (s_access_start |=> pready_o ##1 !pready_o)
        else $error("apb answer not one wait state");
    AST_RESET_VALUES: assert property ($fell(rst_i) |-> st.cfg == MSG_CFG1_RESET && st.sec_low == 16'h0000
                                       && !st.temp_adj)
        else $error("wrong reset values");
    AST_RSV_READ_ZERO: assert property (access && pready_o && !pwrite_i && reg_hit(paddr_i, IDX_MSG_CFG1)
                                        |-> prdata_o[31:8] == 24'h000000)
        else $error("reserved config bits not zero");
    AST_RATE_ADD: assert property (s_adj_tick and st.rate_direction_sel |=> st.rtc_frac == $past(exp_add))
        else $error("rate not added");
    AST_RATE_SUB: assert property (s_adj_tick and !st.rate_direction_sel |=> st.rtc_frac == $past(exp_sub))
        else $error("rate not subtracted");
    AST_NO_ADJ_IDLE: assert property (tick && st.clk_en && !adj_act && !wr_ctrl
                                      |=> st.rtc_frac == $past(st.rtc_frac))
        else $error("fraction moved without adjustment");
    AST_TEMP_COUNT: assert property (tick && st.clk_en && st.temp_adj && st.dur_cnt != 32'h0000_0000 && !wr_rate_hi
                                     |=> st.dur_cnt == $past(st.dur_cnt) - 32'h0000_0001)
        else $error("duration count not stepped");
    AST_TEMP_END: assert property (st.temp_adj && st.dur_cnt == 32'h0000_0000 && !wr_rate_hi
                                   |=> !st.temp_adj)
        else $error("temporary mode not ended");
    AST_TEMP_STOP: assert property (wr_rate_hi && !pwdata_i[TEMP_ADJ_BIT] |=> !temp_adjusting_o [*2])
        else $error("temporary mode not stopped");
    AST_CFG_OUT: assert property (wr_cfg |=> peer_to_peer_transparent_o == $past(pwdata_i[CFG_P2P_BIT])
                                  && one_step_o == $past(pwdata_i[CFG_ONE_BIT]))
        else $error("config output not updated");
    AST_READ_CAPTURE: assert property (wr_ctrl && pwdata_i[CTRL_READ_BIT] |=> st.sec_low == $past(st.rtc_sec))
        else $error("seconds not captured");
endmodule

// [hw/pcra_pkg.sv]
package pcra_pkg;
    localparam int ADDR_W = 16;
    // printed offsets are register indices; byte address is four times that
    localparam logic [15:0] IDX_CLK_CTRL  = 16'h0500;
    localparam logic [15:0] IDX_SEC_LOW   = 16'h050A;
    localparam logic [15:0] IDX_RATE_HIGH = 16'h050C;
    localparam logic [15:0] IDX_RATE_LOW  = 16'h050E;
    localparam logic [15:0] IDX_DUR_HIGH  = 16'h0510;
    localparam logic [15:0] IDX_DUR_LOW   = 16'h0512;
    localparam logic [15:0] IDX_MSG_CFG1  = 16'h0514;
    // clock control bits
    localparam int CTRL_RESET_BIT = 0;
    localparam int CTRL_EN_BIT    = 1;
    localparam int CTRL_CONT_BIT  = 2;
    localparam int CTRL_LOAD_BIT  = 3;
    localparam int CTRL_READ_BIT  = 4;
    // rate high word bits
    localparam int RATE_DIR_BIT = 15;
    localparam int TEMP_ADJ_BIT = 14;
    localparam int RATE_HI_W    = 14;
    localparam int RATE_W       = 30;
    // message config 1 bits
    localparam int CFG_AS_BIT   = 7;
    localparam int CFG_PTP_BIT  = 6;
    localparam int CFG_ETH_BIT  = 5;
    localparam int CFG_IPV4_BIT = 4;
    localparam int CFG_IPV6_BIT = 3;
    localparam int CFG_P2P_BIT  = 2;
    localparam int CFG_MST_BIT  = 1;
    localparam int CFG_ONE_BIT  = 0;
    localparam logic [7:0]  MSG_CFG1_RESET = 8'h39;
    localparam logic [15:0] WORD_RESET     = 16'h0000;
    // timing
    localparam int CLK_FREQ_HZ  = 40_000_000;
    localparam int CLK_PERIOD_NS = 25;
    localparam int TICK_FREQ_HZ = 25_000_000;
    localparam int TICK_GCD_HZ  = 5_000_000;
    localparam int TICK_NUM     = TICK_FREQ_HZ / TICK_GCD_HZ;
    localparam int TICK_DEN     = CLK_FREQ_HZ / TICK_GCD_HZ;
    localparam int NS_PER_SEC   = 1_000_000_000;
    localparam int TICK_NS      = NS_PER_SEC / TICK_FREQ_HZ;
endpackage

// [hw/pcra_tick.sv]
`timescale 1ns/1ps
// fractional divider: TICK_NUM pulses every TICK_DEN clocks, jitter of one clock
module pcra_tick (
    // clock and reset
    input  wire logic clock_i,
    input  wire logic rst_i,
    // tick out
    output logic      tick_o
);
    import pcra_pkg::*;

    typedef struct packed {
        logic [3:0] acc;
        logic       tick;
    } pcra_tick_st_t;

    pcra_tick_st_t st;
    pcra_tick_st_t next_st;

    always_comb begin
        next_st      = st;
        next_st.acc  = st.acc + 4'(TICK_NUM);
        next_st.tick = 1'b0;
        if (next_st.acc >= 4'(TICK_DEN)) begin
            next_st.acc  = next_st.acc - 4'(TICK_DEN);
            next_st.tick = 1'b1;
        end
    end

    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign tick_o = st.tick;
endmodule

// [sim/pcra_tb_top.sv]
`timescale 1ns/1ps
module ptp_clock_rate_adjust_config_tb_top;
    import pcra_pkg::*;
    logic        clock_i;
    logic        rst_i;
    logic        psel_i;
    logic        penable_i;
    logic        pwrite_i;
    logic [15:0] paddr_i;
    logic [31:0] pwdata_i;
    logic [31:0] prdata_o;
    logic        pready_o;
    logic        pslverr_o;
    logic [7:0]  cfg_pins;
    logic [15:0] rtc_sec_o;
    logic [29:0] rtc_ns_o;
    logic        temp_adjusting_o;
    int          fail_count;
    int          tests_run;
    logic [31:0] v;
    logic [31:0] d;
    logic [31:0] r;
    logic        e;
    int          n;

    pcra_top i_dut (
        .clock_i(clock_i), .rst_i(rst_i), .psel_i(psel_i), .penable_i(penable_i),
        .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
        .pready_o(pready_o), .pslverr_o(pslverr_o), .as_mode_en_o(cfg_pins[7]),
        .ptp_mode_en_o(cfg_pins[6]), .detect_eth_o(cfg_pins[5]), .detect_ipv4_o(cfg_pins[4]),
        .detect_ipv6_o(cfg_pins[3]), .peer_to_peer_transparent_o(cfg_pins[2]),
        .master_sel_o(cfg_pins[1]), .one_step_o(cfg_pins[0]), .rtc_sec_o(rtc_sec_o),
        .rtc_ns_o(rtc_ns_o), .temp_adjusting_o(temp_adjusting_o)
    );

    initial begin
        clock_i = 1'b0;
        forever #12.5 clock_i = ~clock_i;
    end

    task automatic print_verdict();
        $display("comparisons %0d, mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    task automatic check_val(input string name, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            fail_count++;
            $display("MISMATCH %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic check_range(input string name, input logic [31:0] lo, input logic [31:0] hi,
                               input logic [31:0] got);
        tests_run++;
        if ((^got === 1'bx) || got < lo || got > hi) begin
            fail_count++;
            $display("MISMATCH %s expected %0d..%0d seen %0d", name, lo, hi, got);
        end
    endtask

    function automatic logic [15:0] ba(input logic [15:0] idx);
        return {idx[13:0], 2'b00};
    endfunction

    // called just after a rising edge; ends one idle cycle after release so drivers never collide
    task automatic apb(input logic wr, input logic [15:0] addr, input logic [31:0] wd,
                       output logic [31:0] rdv, output logic err);
        int   k;
        logic to;
        psel_i    <= 1'b1;
        penable_i <= 1'b0;
        pwrite_i  <= wr;
        paddr_i   <= addr;
        pwdata_i  <= wd;
        @(posedge clock_i);
        penable_i <= 1'b1;
        k = 0;
        // pready, read data and error are taken as sampled at the rising edge
        do begin
            @(posedge clock_i);
            k++;
        end while (pready_o !== 1'b1 && k < 16);
        to  = (pready_o !== 1'b1);
        rdv = prdata_o;
        err = pslverr_o;
        psel_i    <= 1'b0;
        penable_i <= 1'b0;
        @(posedge clock_i);
        if (to) begin
            fail_count++;
            $display("MISMATCH pready expected 1 seen timeout");
            print_verdict();
        end
    endtask

    task automatic wr(input logic [15:0] idx, input logic [31:0] wd);
        logic [31:0] x;
        logic        er;
        apb(1'b1, ba(idx), wd, x, er);
        check_val("write error flag", 32'h0, {31'h0, er});
    endtask

    task automatic rd(input logic [15:0] idx, output logic [31:0] x);
        logic er;
        apb(1'b0, ba(idx), 32'h0, x, er);
        check_val("read error flag", 32'h0, {31'h0, er});
    endtask

    // ns advance over a whole number of 8-clock tick periods, so the tick count is exact
    task automatic measure(input int cyc, output logic [31:0] delta);
        logic [29:0] a;
        @(negedge clock_i);
        a = rtc_ns_o;
        repeat (cyc) @(negedge clock_i);
        delta = {2'b00, rtc_ns_o} - {2'b00, a};
        @(posedge clock_i);
    endtask

    task automatic done(input string name);
        $display("test %s finished, mismatches so far %0d", name, fail_count);
    endtask

    initial begin
        repeat (100000) @(posedge clock_i);
        fail_count++;
        $display("MISMATCH run length expected below limit seen limit");
        print_verdict();
    end

    initial begin
        rst_i = 1'b1;
        psel_i = 1'b0;
        penable_i = 1'b0;
        pwrite_i = 1'b0;
        paddr_i = 16'h0000;
        pwdata_i = 32'h0;
        fail_count = 0;
        tests_run = 0;
        v = $urandom(17);
        repeat (3) @(posedge clock_i);
        rst_i <= 1'b0;
        @(posedge clock_i);

        check_val("config pins", 32'h39, {24'h0, cfg_pins});
        rd(IDX_SEC_LOW, r);
        check_val("seconds low", 32'h0, r);
        rd(IDX_RATE_HIGH, r);
        check_val("rate high", 32'h0, r);
        rd(IDX_RATE_LOW, r);
        check_val("rate low", 32'h0, r);
        rd(IDX_DUR_HIGH, r);
        check_val("duration high", 32'h0, r);
        rd(IDX_DUR_LOW, r);
        check_val("duration low", 32'h0, r);
        rd(IDX_MSG_CFG1, r);
        check_val("config word", 32'h39, r);
        done("reset values");

        // walking one over the config bits, then all ones, all zeros and random words
        for (int i = 0; i < 14; i++) begin
            v = (i < 8) ? (32'h1 << i) : (i == 8) ? 32'hFFFFFFFF : (i == 9) ? 32'h0 : $urandom;
            wr(IDX_MSG_CFG1, v);
            rd(IDX_MSG_CFG1, r);
            check_val("config word", {24'h0, v[7:0]}, r);
            check_val("config pins", {24'h0, v[7:0]}, {24'h0, cfg_pins});
            wr(IDX_SEC_LOW, v);
            rd(IDX_SEC_LOW, r);
            check_val("seconds low", {16'h0, v[15:0]}, r);
            wr(IDX_RATE_LOW, v);
            rd(IDX_RATE_LOW, r);
            check_val("rate low", {16'h0, v[15:0]}, r);
            wr(IDX_RATE_HIGH, v & 32'h0000BFFF);
            rd(IDX_RATE_HIGH, r);
            check_val("rate high", {16'h0, v[15:0] & 16'hBFFF}, r);
            wr(IDX_DUR_HIGH, ~v);
            wr(IDX_DUR_LOW, v);
            rd(IDX_DUR_HIGH, r);
            check_val("duration high", {16'h0, ~v[15:0]}, r);
            rd(IDX_DUR_LOW, r);
            check_val("duration low", {16'h0, v[15:0]}, r);
        end
        done("register access");

        wr(IDX_SEC_LOW, 32'h1234);
        apb(1'b0, ba(16'h0516), 32'h0, r, e);
        check_val("unmapped error", 32'h1, {31'h0, e});
        check_val("unmapped data", 32'h0, r);
        apb(1'b1, ba(IDX_SEC_LOW) | 16'h0001, 32'hFFFF, r, e);
        check_val("unaligned error", 32'h1, {31'h0, e});
        rd(IDX_SEC_LOW, r);
        check_val("seconds low", 32'h1234, r);
        done("refused access");

        v = $urandom & 32'hFFFF;
        wr(IDX_SEC_LOW, v);
        wr(IDX_CLK_CTRL, 32'hA);
        @(negedge clock_i);
        check_val("loaded seconds", v, {16'h0, rtc_sec_o});
        @(posedge clock_i);
        wr(IDX_SEC_LOW, ~v & 32'hFFFF);
        wr(IDX_CLK_CTRL, 32'h12);
        rd(IDX_SEC_LOW, r);
        check_val("captured seconds", v, r);
        done("load and capture");

        // 128 clocks hold 80 ticks of 40 ns; rate 0.5 ns moves that by 40 ns either way
        measure(128, d);
        check_range("plain advance", 3200, 3200, d);
        wr(IDX_RATE_LOW, 32'h0);
        for (int dir = 1; dir >= 0; dir--) begin
            wr(IDX_RATE_HIGH, (dir << 15) | 32'h2000);
            wr(IDX_CLK_CTRL, 32'h6);
            measure(128, d);
            check_range("continuous advance", dir ? 3239 : 3159, dir ? 3241 : 3161, d);
            wr(IDX_CLK_CTRL, 32'h2);
        end
        done("continuous adjust");

        wr(IDX_DUR_HIGH, 32'h0);
        wr(IDX_DUR_LOW, 32'd40);
        wr(IDX_RATE_HIGH, 32'hE000);
        n = 0;
        @(negedge clock_i);
        check_val("temp mode on", 32'h1, {31'h0, temp_adjusting_o});
        while (temp_adjusting_o === 1'b1 && n < 300) begin
            @(negedge clock_i);
            n++;
        end
        check_range("temp length in clocks", 58, 66, n);
        @(posedge clock_i);
        rd(IDX_RATE_HIGH, r);
        check_val("temp mode cleared", 32'hA000, r);

        // high duration word alone keeps the adjustment running far past this window
        wr(IDX_DUR_HIGH, 32'h1);
        wr(IDX_DUR_LOW, 32'h0);
        wr(IDX_RATE_HIGH, 32'h6000);
        measure(128, d);
        check_range("temp subtract", 3159, 3161, d);
        check_val("temp still on", 32'h1, {31'h0, temp_adjusting_o});
        wr(IDX_RATE_HIGH, 32'h2000);
        @(negedge clock_i);
        check_val("temp stopped", 32'h0, {31'h0, temp_adjusting_o});
        @(posedge clock_i);
        measure(128, d);
        check_range("advance after stop", 3199, 3201, d);
        done("temporary adjust");

        print_verdict();
    end
endmodule
